// *** common/iwd_defs.vh ***
// Field positions, class codes, operation codes and timing counts of the instruction decoder
`ifndef IWD_DEFS_VH
`define IWD_DEFS_VH
`define IWD_INSTR_W       14
`define IWD_CLASS_HI      13
`define IWD_CLASS_LO      12
`define IWD_CLASS_BYTE    2'h0
`define IWD_CLASS_BIT     2'h1
`define IWD_CLASS_JUMP    2'h2
`define IWD_CLASS_LIT     2'h3
`define IWD_DEST_BIT      7
`define IWD_FILE_HI       6
`define IWD_FILE_LO       0
`define IWD_BSEL_HI       9
`define IWD_BSEL_LO       7
`define IWD_K8_HI         7
`define IWD_K11_HI        10
`define IWD_OPS_HI        11
`define IWD_OPS_LO        8
`define IWD_JUMP_GOTO     11
`define IWD_FILE_MAX      7'h7f
`define IWD_PHASES        4
`define IWD_PHASE_W       2
`define IWD_PH_READ       2'h1
`define IWD_PH_EXEC       2'h2
`define IWD_PH_WRITE      2'h3
`define IWD_TCNT_ADDR     7'h01
`define IWD_PORT_A_ADDR   7'h05
`define IWD_PORT_B_ADDR   7'h06
`define IWD_PORT_C_ADDR   7'h07
// Operation codes presented to the datapath
`define IWD_OP_NOP        5'h00
`define IWD_OP_MOVWF      5'h01
`define IWD_OP_CLR        5'h02
`define IWD_OP_SUBWF      5'h03
`define IWD_OP_DECF       5'h04
`define IWD_OP_IORWF      5'h05
`define IWD_OP_ANDWF      5'h06
`define IWD_OP_XORWF      5'h07
`define IWD_OP_ADDWF      5'h08
`define IWD_OP_MOVF       5'h09
`define IWD_OP_COMF       5'h0a
`define IWD_OP_INCF       5'h0b
`define IWD_OP_DECFSZ     5'h0c
`define IWD_OP_RRF        5'h0d
`define IWD_OP_RLF        5'h0e
`define IWD_OP_SWAPF      5'h0f
`define IWD_OP_INCFSZ     5'h10
`define IWD_OP_BCF        5'h11
`define IWD_OP_BSF        5'h12
`define IWD_OP_BTFSC      5'h13
`define IWD_OP_BTFSS      5'h14
`define IWD_OP_CALL       5'h15
`define IWD_OP_GOTO       5'h16
`define IWD_OP_MOVLW      5'h17
`define IWD_OP_RETLW      5'h18
`define IWD_OP_IORLW      5'h19
`define IWD_OP_ANDLW      5'h1a
`define IWD_OP_XORLW      5'h1b
`define IWD_OP_SUBLW      5'h1c
`define IWD_OP_ADDLW      5'h1d
`define IWD_OP_RETURN     5'h1e
`define IWD_OP_RETFIE     5'h1f
`define IWD_OP_CLRWDT     5'h01
`define IWD_OP_SLEEP      5'h02
`endif

// *** rtl/iwd_phase_gen.v ***
// Four-phase instruction cycle sequencer driven by clock enable
`timescale 1ns/1ns
`include "iwd_defs.vh"
module iwd_phase_gen
(
   input  wire       clk_sys,    // System clock
   input  wire       rst_n,      // Synchronised reset, active low
   input  wire       osc_en,     // One-cycle oscillator period enable
   output reg  [1:0] phase_r,    // Current phase, 0..3
   output wire       cyc_start   // Pulse: last phase of a cycle, on the edge into phase 0
);
   wire [1:0] phase_nxt;

   assign phase_nxt = (phase_r == (`IWD_PHASES - 1)) ? 2'h0 : phase_r + 2'h1;
   assign cyc_start = osc_en & (phase_r == (`IWD_PHASES - 1));

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         phase_r <= 2'h0;
      else if (osc_en)
         phase_r <= phase_nxt;  // [RULE7]
   end
endmodule // iwd_phase_gen

// *** rtl/iwd_decoder.v ***
// Instruction word decoder and cycle timer for the 8-bit core
//
// Notes on behaviour
// [RULE1] Each instruction is one 14-bit word: opcode plus operand fields.
// [RULE2] Every word falls into byte, bit, or literal/control class.
// [RULE3] Destination 0 writes working register, 1 writes back to file register.
// [RULE4] File address operand spans registers 0x00 to 0x7F.
// [RULE5] Bit select picks one of eight bits of the file register.
// [RULE6] Literal operand is 8 or 11 bits depending on instruction.
// [RULE7] An instruction cycle is four oscillator periods, phased accordingly.
// [RULE8] One cycle, or two with a no-op second when program counter changes.
// [RULE9] Named file register is always read, modified, then stored. The code stores it only when writes_file is set.
// [RULE10] Don't-care opcode bits do not change the decoded operation.
// [RULE11] Port registers modified from themselves read pin levels, not latches.
// [RULE12] Writing the timer-zero register clears its prescaler when assigned.
// [RULE13] Top two bits choose the class before further decoding.
`timescale 1ns/1ns
`include "iwd_defs.vh"
module iwd_decoder
(
   input  wire        clk_sys,        // System clock, 125 MHz
   input  wire        resetn,         // Asynchronous reset, active low
   input  wire        osc_en,         // Oscillator period enable pulse
   input  wire [13:0] instr_word,     // Fetched instruction word
   input  wire        skip_true,      // Datapath: conditional test true
   input  wire        psa_to_wdt,     // Prescaler assigned to watchdog
   output reg  [1:0]  instr_class_r,  // Decoded class
   output reg  [4:0]  op_code_r,      // Decoded operation
   output reg  [6:0]  file_addr_r,    // File register address
   output reg  [2:0]  bit_sel_r,      // Bit position
   output reg  [7:0]  bit_mask_r,     // One-hot bit mask
   output reg  [10:0] literal_r,      // Literal operand, zero-extended
   output reg         lit_wide_r,     // Literal is 11 bits
   output reg         dest_file_r,    // Result goes to file register
   output reg         dest_w_r,       // Result goes to working register
   output reg         file_rd_r,      // Read strobe for file register
   output reg         file_wr_r,      // Write strobe for file register
   output reg         read_pins_r,    // Read samples pin levels
   output reg         prescale_clr_r, // Clear timer-zero prescaler
   output reg         pc_load_r,      // Program counter takes a new value
   output reg         stall_nop_r,    // Second cycle executing as no-op
   output reg         fetch_en,       // New word taken this cycle start
   output wire [1:0]  phase,          // Current phase within cycle
   output reg         illegal_r       // Unassigned encoding seen
);
   reg         rst_meta_r;
   reg         rst_sync_r;
   wire        rst_n;
   wire [1:0]  phase_w;
   wire        cyc_start;
   reg  [13:0] ir_r;
   reg         two_cyc_r;
   reg  [1:0]  cls;
   reg  [4:0]  op;
   reg         uses_file;
   reg         writes_file;
   reg         writes_w;
   reg         changes_pc;
   reg         cond;
   reg         wide;
   reg         bad;
   reg         misc_clrwdt;
   reg         misc_sleep;

   always @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end
   assign rst_n = rst_sync_r;

   iwd_phase_gen u_phase
   (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .osc_en    (osc_en),
      .phase_r   (phase_w),
      .cyc_start (cyc_start)
   );
   assign phase = phase_w;

   // Port registers must read pins so outputs driven low externally are seen
   function is_port;
      input [6:0] a;
      begin
         is_port = (a == `IWD_PORT_A_ADDR) | (a == `IWD_PORT_B_ADDR) |
                   (a == `IWD_PORT_C_ADDR);
      end
   endfunction

   // Byte-class operation from the four-bit opcode field
   function [4:0] byte_op;
      input [3:0] f;
      begin
         case (f)
            4'h7:    byte_op = `IWD_OP_ADDWF;
            4'h5:    byte_op = `IWD_OP_ANDWF;
            4'h1:    byte_op = `IWD_OP_CLR;
            4'h9:    byte_op = `IWD_OP_COMF;
            4'h3:    byte_op = `IWD_OP_DECF;
            4'hb:    byte_op = `IWD_OP_DECFSZ;
            4'ha:    byte_op = `IWD_OP_INCF;
            4'hf:    byte_op = `IWD_OP_INCFSZ;
            4'h4:    byte_op = `IWD_OP_IORWF;
            4'h8:    byte_op = `IWD_OP_MOVF;
            4'hd:    byte_op = `IWD_OP_RLF;
            4'hc:    byte_op = `IWD_OP_RRF;
            4'h2:    byte_op = `IWD_OP_SUBWF;
            4'he:    byte_op = `IWD_OP_SWAPF;
            4'h6:    byte_op = `IWD_OP_XORWF;
            default: byte_op = `IWD_OP_MOVWF;
         endcase
      end
   endfunction

   always @*
   begin
      cls         = ir_r[`IWD_CLASS_HI:`IWD_CLASS_LO];  // [RULE13] [RULE2]
      op          = `IWD_OP_NOP;
      uses_file   = 1'b0;
      writes_file = 1'b0;
      writes_w    = 1'b0;
      changes_pc  = 1'b0;
      cond        = 1'b0;
      wide        = 1'b0;
      bad         = 1'b0;
      misc_clrwdt = 1'b0;
      misc_sleep  = 1'b0;
      case (cls)
         `IWD_CLASS_BYTE:
         begin
            if (ir_r[`IWD_OPS_HI:`IWD_OPS_LO] == 4'h0)
            begin
               if (ir_r[`IWD_DEST_BIT])
               begin
                  op          = `IWD_OP_MOVWF;
                  uses_file   = 1'b1;
                  writes_file = 1'b1;
               end
               else if (ir_r[6:0] == 7'h08)
               begin
                  op         = `IWD_OP_RETURN;
                  changes_pc = 1'b1;
               end
               else if (ir_r[6:0] == 7'h09)
               begin
                  op         = `IWD_OP_RETFIE;
                  changes_pc = 1'b1;
               end
               else if (ir_r[6:0] == 7'h64)
                  misc_clrwdt = 1'b1;
               else if (ir_r[6:0] == 7'h63)
                  misc_sleep = 1'b1;
               else if (ir_r[4:0] == 5'h00)
                  op = `IWD_OP_NOP;        // Bits 6:5 ignored [RULE10]
               else
                  bad = 1'b1;
            end
            else if ((ir_r[`IWD_OPS_HI:`IWD_OPS_LO] == 4'h1) && !ir_r[`IWD_DEST_BIT])
            begin
               op       = `IWD_OP_CLR;     // Clear W, low bits ignored [RULE10]
               writes_w = 1'b1;
            end
            else
            begin
               op          = byte_op(ir_r[`IWD_OPS_HI:`IWD_OPS_LO]);
               uses_file   = 1'b1;
               writes_file = ir_r[`IWD_DEST_BIT];   // [RULE3]
               writes_w    = ~ir_r[`IWD_DEST_BIT];  // [RULE3]
               cond        = (op == `IWD_OP_DECFSZ) | (op == `IWD_OP_INCFSZ);
            end
         end
         `IWD_CLASS_BIT:
         begin
            uses_file = 1'b1;
            case (ir_r[11:10])
               2'h0:    op = `IWD_OP_BCF;
               2'h1:    op = `IWD_OP_BSF;
               2'h2:    op = `IWD_OP_BTFSC;
               default: op = `IWD_OP_BTFSS;
            endcase
            writes_file = ~ir_r[11];
            cond        = ir_r[11];
         end
         `IWD_CLASS_JUMP:
         begin
            op         = ir_r[`IWD_JUMP_GOTO] ? `IWD_OP_GOTO : `IWD_OP_CALL;
            wide       = 1'b1;                      // [RULE6]
            changes_pc = 1'b1;
         end
         default:
         begin
            writes_w = 1'b1;
            casez (ir_r[11:8])
               4'b00??: op = `IWD_OP_MOVLW;         // [RULE10]
               4'b01??:
               begin
                  op         = `IWD_OP_RETLW;
                  changes_pc = 1'b1;
               end
               4'b1000: op = `IWD_OP_IORLW;
               4'b1001: op = `IWD_OP_ANDLW;
               4'b1010: op = `IWD_OP_XORLW;
               4'b110?: op = `IWD_OP_SUBLW;
               4'b111?: op = `IWD_OP_ADDLW;
               default:
               begin
                  writes_w = 1'b0;
                  bad      = 1'b1;
               end
            endcase
         end
      endcase
   end

   always @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ir_r           <= 14'h0000;
         two_cyc_r      <= 1'b0;
         fetch_en       <= 1'b0;
         instr_class_r  <= 2'h0;
         op_code_r      <= 5'h00;
         file_addr_r    <= 7'h00;
         bit_sel_r      <= 3'h0;
         bit_mask_r     <= 8'h00;
         literal_r      <= 11'h000;
         lit_wide_r     <= 1'b0;
         dest_file_r    <= 1'b0;
         dest_w_r       <= 1'b0;
         file_rd_r      <= 1'b0;
         file_wr_r      <= 1'b0;
         read_pins_r    <= 1'b0;
         prescale_clr_r <= 1'b0;
         pc_load_r      <= 1'b0;
         stall_nop_r    <= 1'b0;
         illegal_r      <= 1'b0;
      end
      else
      begin
         fetch_en       <= 1'b0;
         file_rd_r      <= 1'b0;
         file_wr_r      <= 1'b0;
         prescale_clr_r <= 1'b0;
         pc_load_r      <= 1'b0;
         if (cyc_start)
         begin
            // Second cycle of a flow change runs as a no-op; no word is taken, so the offered one stays
            if (two_cyc_r)
            begin
               ir_r        <= 14'h0000;                         // [RULE8]
               two_cyc_r   <= 1'b0;
               stall_nop_r <= 1'b1;
            end
            else
            begin
               ir_r        <= instr_word;                       // [RULE1]
               fetch_en    <= 1'b1;
               stall_nop_r <= 1'b0;
            end
         end
         if (osc_en)  // Not an else: WRITE strobes share the edge that takes the next word
         begin
            case (phase_w)
               `IWD_PH_READ:
               begin
                  instr_class_r <= cls;
                  op_code_r     <= misc_clrwdt ? `IWD_OP_CLRWDT :
                                   (misc_sleep ? `IWD_OP_SLEEP : op);
                  file_addr_r   <= ir_r[`IWD_FILE_HI:`IWD_FILE_LO] & `IWD_FILE_MAX; // [RULE4]
                  bit_sel_r     <= ir_r[`IWD_BSEL_HI:`IWD_BSEL_LO];   // [RULE5]
                  bit_mask_r    <= 8'h01 << ir_r[`IWD_BSEL_HI:`IWD_BSEL_LO]; // [RULE5]
                  literal_r     <= wide ? ir_r[`IWD_K11_HI:0] :
                                   {3'h0, ir_r[`IWD_K8_HI:0]};  // [RULE6]
                  lit_wide_r    <= wide;
                  dest_file_r   <= writes_file;                 // [RULE3]
                  dest_w_r      <= writes_w;
                  illegal_r     <= bad;
                  file_rd_r     <= uses_file;                   // Even for write-only [RULE9]
                  read_pins_r   <= uses_file &
                                   is_port(ir_r[`IWD_FILE_HI:`IWD_FILE_LO]); // [RULE11]
               end
               `IWD_PH_EXEC:
               begin
                  // Unconditional flow change or true test takes a second cycle
                  if (changes_pc | (cond & skip_true))
                  begin
                     two_cyc_r <= 1'b1;                         // [RULE8]
                     pc_load_r <= changes_pc;
                  end
               end
               `IWD_PH_WRITE:
               begin
                  file_wr_r      <= writes_file;                // [RULE9]
                  prescale_clr_r <= writes_file & ~psa_to_wdt &
                                    (ir_r[`IWD_FILE_HI:`IWD_FILE_LO] == `IWD_TCNT_ADDR); // [RULE12]
               end
               default:
               begin
                  file_rd_r <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule // iwd_decoder

// *** bench/iwd_decoder_sva.sv ***
// Port-level timing and field checks for the instruction decoder
`timescale 1ns/1ns
module iwd_decoder_sva
(
   input wire        clk_sys,        // Clock
   input wire        resetn,         // Reset
   input wire        osc_en,         // Period enable
   input wire        psa_to_wdt,     // Prescaler owner
   input wire [1:0]  instr_class_r,  // Class
   input wire [6:0]  file_addr_r,    // File address
   input wire [2:0]  bit_sel_r,      // Bit select
   input wire [7:0]  bit_mask_r,     // Bit mask
   input wire        lit_wide_r,     // Wide literal
   input wire        dest_file_r,    // To file
   input wire        dest_w_r,       // To working reg
   input wire        file_rd_r,      // Read strobe
   input wire        file_wr_r,      // Write strobe
   input wire        read_pins_r,    // Pin read
   input wire        prescale_clr_r, // Prescaler clear
   input wire        pc_load_r,      // Flow change
   input wire        stall_nop_r,    // No-op cycle
   input wire        fetch_en,       // Word taken
   input wire [1:0]  phase           // Phase
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   a_phase_step: assert property (phase == $past(phase) + {1'b0, $past(osc_en)})
      else $error("phase did not follow osc_en");
   a_fetch_on_take: assert property (fetch_en |-> $past(osc_en && phase == 2'h3))
      else $error("fetch outside take edge");
   a_stall_no_fetch: assert property (stall_nop_r |-> !fetch_en)
      else $error("word taken in no-op cycle");
   a_pc_exec: assert property (pc_load_r |-> $past(osc_en && phase == 2'h2))
      else $error("pc load outside exec");
   a_read_phase: assert property (file_rd_r |-> $past(osc_en && phase == 2'h1))
      else $error("file read outside read phase");
   a_write_phase: assert property (file_wr_r |->
      $past(osc_en && phase == 2'h3) && dest_file_r)
      else $error("file write bad timing or target");
   a_dest_split: assert property (!(dest_file_r && dest_w_r))
      else $error("two destinations");
   a_pins_sample: assert property (file_rd_r |->
      read_pins_r == (file_addr_r >= 7'h05 && file_addr_r <= 7'h07))
      else $error("pin sampling mismatch");
   a_prescale_clear: assert property (prescale_clr_r ==
      (file_wr_r && file_addr_r == 7'h01 && !$past(psa_to_wdt)))
      else $error("prescaler clear mismatch");
   a_mask_onehot: assert property (instr_class_r == 2'h1 |->
      bit_mask_r == (8'h01 << bit_sel_r))
      else $error("bit mask mismatch");
   a_wide_literal: assert property (lit_wide_r == (instr_class_r == 2'h2))
      else $error("literal width mismatch");
   c_flow: cover property (pc_load_r);
   c_stall: cover property (stall_nop_r && !pc_load_r);
   c_prescale: cover property (prescale_clr_r);
   c_pins: cover property (file_rd_r && read_pins_r);
endmodule // iwd_decoder_sva

bind iwd_decoder iwd_decoder_sva u_sva
(
   .clk_sys, .resetn, .osc_en, .psa_to_wdt, .instr_class_r, .file_addr_r, .bit_sel_r,
   .bit_mask_r, .lit_wide_r, .dest_file_r, .dest_w_r, .file_rd_r, .file_wr_r, .read_pins_r,
   .prescale_clr_r, .pc_load_r, .stall_nop_r, .fetch_en, .phase
);

// *** bench/iwd_prog_mem.sv ***
// Program memory and datapath skip model facing the decoder
`timescale 1ns/1ns
module iwd_prog_mem
(
   input  wire        clk_sys,    // Clock
   input  wire        fetch_en,   // Word taken
   output wire [13:0] instr_word, // Word offered
   output reg         skip_true   // Test result of executing word
);
   reg [14:0] mem [0:127];
   reg [6:0]  ptr_r;
   initial
   begin
      ptr_r = 7'h00;
      skip_true = 1'b0;
   end
   // A refused word stays on offer until it is taken
   assign instr_word = mem[ptr_r][13:0];
   always @(negedge clk_sys)
   begin
      if (fetch_en)
      begin
         skip_true <= mem[ptr_r][14];
         ptr_r     <= ptr_r + 7'h01;
      end
   end
endmodule // iwd_prog_mem

// *** bench/test_instr_word_decoder.sv ***
// Self-checking bench for the instruction decoder
`timescale 1ns/1ns
module test_instr_word_decoder;
   reg          clk_sys, resetn, osc_en, psa_to_wdt, drive, ev, pend, st_d;
   wire [13:0]  instr_word;
   wire         skip_true, fetch_en, stall_nop_r, file_rd_r, file_wr_r, dest_file_r, illegal_r;
   wire         dest_w_r, pc_load_r;
   wire [1:0]   instr_class_r, phase;
   wire [4:0]   op_code_r;
   wire [6:0]   file_addr_r;
   wire [7:0]   bit_mask_r;
   wire [10:0]  literal_r;
   integer      miscompares, checks_done, seed, n_words, i;
   integer      exp_rd, exp_wr, exp_stall, got_rd, got_wr, got_stall, exp_pc, got_pc;
   logic [19:0] q[$];
   logic [19:0] e;
   logic [31:0] r;
   logic [13:0] w;
   logic [13:0] fixed [0:15] = '{14'h0000, 14'h0060, 14'h0008, 14'h0009, 14'h0063, 14'h0064,
      14'h0001, 14'h01ff, 14'h017f, 14'h0081, 14'h3b55, 14'h3355, 14'h3f00, 14'h2fff,
      14'h2000, 14'h3455};

   iwd_decoder u_dut (.clk_sys, .resetn, .osc_en, .instr_word, .skip_true, .psa_to_wdt,
      .instr_class_r, .op_code_r, .file_addr_r, .bit_sel_r(), .bit_mask_r, .literal_r,
      .lit_wide_r(), .dest_file_r, .dest_w_r, .file_rd_r, .file_wr_r, .read_pins_r(),
      .prescale_clr_r(), .pc_load_r, .stall_nop_r, .fetch_en, .phase, .illegal_r);
   iwd_prog_mem u_mem (.clk_sys, .fetch_en, .instr_word, .skip_true);

   function automatic logic [5:0] exp_op(input logic [13:0] c);
      logic [3:0] n;
      n = c[11:8];
      exp_op = 6'h20;
      case (c[13:12])
         2'h0:
            if (n != 4'h0) exp_op = {2'h0, n} + 6'h01;
            else if (c[7]) exp_op = 6'h01;
            else if (c[7:0] == 8'h08) exp_op = 6'h1e;
            else if (c[7:0] == 8'h09) exp_op = 6'h1f;
            else if (c[7:0] == 8'h63) exp_op = 6'h02;
            else if (c[7:0] == 8'h64) exp_op = 6'h01;
            else if (c[4:0] == 5'h00) exp_op = 6'h00;
         2'h1: exp_op = {4'h4, c[11:10]} + 6'h01;
         2'h2: exp_op = c[11] ? 6'h16 : 6'h15;
         default:
            if (n[3:2] == 2'h0) exp_op = 6'h17;
            else if (n[3:2] == 2'h1) exp_op = 6'h18;
            else if (n[3:1] == 3'h6) exp_op = 6'h1c;
            else if (n[3:1] == 3'h7) exp_op = 6'h1d;
            else if (n != 4'hb) exp_op = {2'h0, n} + 6'h11;
      endcase
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done = checks_done + 1;
      if (seen !== want)
      begin
         miscompares = miscompares + 1;
         $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   // Skip answer is kept only for conditional words, as a real datapath would
   task automatic add_word(input logic [13:0] c, input logic sk);
      logic [5:0] o;
      logic       t;
      o = exp_op(c);
      t = sk && (o == 6'h0c || o == 6'h10 || o == 6'h13 || o == 6'h14);
      u_mem.mem[n_words] = {t, c};
      q.push_back({c, o});
      n_words = n_words + 1;
      if (o == 6'h15 || o == 6'h16 || o == 6'h18 || o == 6'h1e || o == 6'h1f)
         exp_pc = exp_pc + 1;
      if (t || o == 6'h15 || o == 6'h16 || o == 6'h18 || o == 6'h1e || o == 6'h1f)
         exp_stall = exp_stall + 1;
      if (c[13:12] == 2'h1 || (c[13:12] == 2'h0 && (c[11:9] != 3'h0 || c[7])))
         exp_rd = exp_rd + 1;
      if ((c[13:12] == 2'h0 && c[7]) || c[13:11] == 3'h2)
         exp_wr = exp_wr + 1;
   endtask

   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys)
      ev <= osc_en && phase == 2'h1;

   always @(negedge clk_sys)
   begin
      if (drive)
      begin
         r = $random(seed);
         osc_en <= r[1:0] != 2'h0;
         if (fetch_en)
            psa_to_wdt <= r[2];
      end
      if (ev && pend && q.size() > 0)
      begin
         e = q.pop_front();
         w = e[19:6];
         check(instr_class_r, w[13:12]);
         check({illegal_r, op_code_r}, e[5:0]);
         if (!w[13] && (w[12] || w[11:9] != 3'h0 || w[7]))
            check(file_addr_r, w[6:0]);
         if (w[13:12] == 2'h1)
            check(bit_mask_r, 8'h01 << w[9:7]);
         if (w[13])
            check(literal_r, w[12] ? {3'h0, w[7:0]} : w[10:0]);
         if (w[13:12] == 2'h0 && (w[11:8] != 4'h0 || w[7]))
            check({dest_file_r, dest_w_r}, {w[7], !w[7]});
         pend = 1'b0;
      end
      if (fetch_en)
         pend = 1'b1;
      got_rd = got_rd + file_rd_r;
      got_wr = got_wr + file_wr_r;
      got_pc = got_pc + pc_load_r;
      got_stall = got_stall + (stall_nop_r && !st_d);
      st_d = stall_nop_r;
   end

   initial
   begin
      #240000;
      miscompares = miscompares + 1;
      $display("watchdog expired");
      tally_and_finish;
   end

   initial
   begin
      {resetn, osc_en, psa_to_wdt, drive, ev, pend, st_d} = 7'h00;
      {miscompares, checks_done, n_words, exp_rd, exp_wr, exp_stall, exp_pc} = 224'h0;
      {got_rd, got_wr, got_stall, got_pc} = 128'h0;
      seed = 32'h3a65d39e;
      for (i = 0; i < 128; i = i + 1)
         u_mem.mem[i] = 15'h0000;
      for (i = 0; i < 16; i = i + 1)
      begin
         add_word(fixed[i], 1'b1);
         add_word({2'h0, i[3:0], i[0], 7'h05}, 1'b1);
         if (i < 4)
            add_word({2'h1, i[1:0], 3'h7, 7'h01}, i[0]);
      end
      for (i = 0; i < 80; i = i + 1)
      begin
         r = $random(seed);
         w = r[13:0];
         if (r[14])
            w[6:0] = {4'h0, r[17:15]};
         add_word(w, r[20]);
      end
      repeat (5) @(negedge clk_sys);
      resetn = 1'b1;
      repeat (4) @(negedge clk_sys);
      drive = 1'b1;
      wait (q.size() == 0);
      repeat (40) @(negedge clk_sys);
      $display("test decode done");
      check(got_rd, exp_rd);
      check(got_wr, exp_wr);
      check(got_stall, exp_stall);
      check(got_pc, exp_pc);
      $display("test counts done");
      tally_and_finish;
   end
endmodule // test_instr_word_decoder
